// ===== ssu_pkg.sv
// Constants and types shared by the sixty-bit shift unit.
package ssu_pkg;

   // Word and count geometry.
   localparam int unsigned SSU_WORD_WIDTH      = 60;
   localparam int unsigned SSU_WORD_SIGN_BIT   = 59;
   localparam int unsigned SSU_COUNT_WIDTH     = 6;
   localparam int unsigned SSU_COUNT_REG_WIDTH = 18;
   localparam int unsigned SSU_COUNT_SIGN_BIT  = 17;
   localparam int unsigned SSU_OPCODE_WIDTH    = 3;

   // Designator bits that identify the operation.
   localparam int unsigned SSU_CLASS_BIT  = 1;
   localparam int unsigned SSU_SELECT_BIT = 1;
   localparam int unsigned SSU_DIR_BIT    = 0;

   // Pre-rotation that cancels the offset of a complemented count.
   localparam int unsigned SSU_PRE_ROTATE = 3;

   // Rank steps: each rank shifts by flag index times its step.
   localparam int unsigned SSU_RANK_FLAGS = 4;
   localparam int unsigned SSU_RANK1_STEP = 1;
   localparam int unsigned SSU_RANK2_STEP = 4;
   localparam int unsigned SSU_RANK3_STEP = 16;

   // Reset values.
   localparam logic [SSU_WORD_WIDTH-1:0] SSU_RESULT_RESET = 60'h0;
   localparam logic [SSU_RANK_FLAGS-1:0] SSU_FLAGS_RESET  = 4'h1;

   // Periods from issue to the write that moves the result.
   localparam int unsigned SSU_EXEC_PERIODS = 2;

   // Decoded operation, one-hot.
   typedef enum logic [4:0]
   {
      SSU_OP_ROT_IMM = 5'b00001,
      SSU_OP_SHR_IMM = 5'b00010,
      SSU_OP_SHL_SRC = 5'b00100,
      SSU_OP_SHR_SRC = 5'b01000,
      SSU_OP_MASK    = 5'b10000
   } ssu_op_type;

endpackage : ssu_pkg

// ===== ssu_shift_unit.sv
// Sixty-bit shift and mask unit with three right-shift ranks.
//
// Notes on behaviour
// - Five operations, sixty-bit words, result to result_reg.
// - Op 20 rotates result_reg left by count_field.
// - Op 21 shifts result_reg right, sign extended.
// - Op 22 rotates source left; negative count shifts right.
// - Op 23 shifts source right; negative count rotates left.
// - Op 43 builds ones in upper count_field places.
// - Decode only major bit 1, sub bits 0,1.
// - Right operands pass; left operands pre-rotate by three.
// - Mask discards operand, holding register gets zeros.
// - Complement held operand for mask or negative operand.
// - Count from count_field or count_reg low six bits.
// - Complement count for operations 20 and 22.
// - Count bits 0,1 pick first-rank shift 0..3.
// - Count bits 2,3 pick second-rank shift 0..12.
// - Count bits 4,5 pick third-rank shift 0..48.
// - Right shift over 63 withholds rank_enable, clears rank3.
// - Left rotations use circular_mode; ops 20 and 22 complement the count.
// - Op 23 negative count used without complement.
// - Without circular_mode ranks shift right with zero fill.
// - Mask forces ones into rank one, zero fill.
// - Rank three outputs complement only while strobe high.
// - Positive operands recomplemented; negative ones pass.
// - Strobe follows issue; a new issue every period.
`timescale 1ns/100ps

module ssu_shift_unit
#(
   parameter int unsigned WORD_WIDTH = ssu_pkg::SSU_WORD_WIDTH
)
(
   // Clock and reset.
   input  wire logic                                      clock,
   input  wire logic                                      rst,
   // Instruction designators from the current instruction word.
   input  wire logic [ssu_pkg::SSU_OPCODE_WIDTH-1:0]      major_opcode,
   input  wire logic [ssu_pkg::SSU_OPCODE_WIDTH-1:0]      sub_opcode,
   input  wire logic [ssu_pkg::SSU_COUNT_WIDTH-1:0]       count_field,
   // Operand registers.
   input  wire logic [ssu_pkg::SSU_WORD_WIDTH-1:0]        result_reg,
   input  wire logic [ssu_pkg::SSU_WORD_WIDTH-1:0]        source_reg,
   input  wire logic [ssu_pkg::SSU_COUNT_REG_WIDTH-1:0]   count_reg,
   // Go signal from issue logic, one period after issue.
   input  wire logic                                      output_valid_strobe,
   // Result towards result_reg.
   output logic      [ssu_pkg::SSU_WORD_WIDTH-1:0]        result_data,
   output logic                                           result_write
);
   import ssu_pkg::*;

   localparam int unsigned W = SSU_WORD_WIDTH;

   // The rank structure and the three-place correction fit one width only.
   if (WORD_WIDTH != SSU_WORD_WIDTH)
   begin : g_width_check
      $error("ssu_shift_unit: WORD_WIDTH must equal the rank geometry");
   end

   // One rank: shift right by index times step, rotating or zero filling.
   // With no flag set the rank delivers zeros.
   function automatic logic [W-1:0] rank_shift(
      input logic [W-1:0]                v,
      input logic [SSU_RANK_FLAGS-1:0]   flags,
      input int unsigned                 step,
      input logic                        circ);
      logic [2*W-1:0] dbl;
      logic [W-1:0]   r;
      r = '0;
      for (int i = 0; i < SSU_RANK_FLAGS; i++)
      begin
         if (flags[i])
         begin
            dbl = circ ? {v, v} : {{W{1'b0}}, v};
            dbl = dbl >> (i * step);
            r   = dbl[W-1:0];
         end
      end
      return r;
   endfunction : rank_shift

   // Two count bits select exactly one of four flags.
   function automatic logic [SSU_RANK_FLAGS-1:0] flag_decode(
      input logic [1:0] bits);
      return 4'h1 << bits;
   endfunction : flag_decode

   // Issue-stage state.
   ssu_op_type                    op;
   logic [W-1:0]                  hold;
   logic                          complement_flag;
   logic                          recomplement;
   logic                          circular_mode;
   logic [SSU_RANK_FLAGS-1:0]     rank1_flags;
   logic [SSU_RANK_FLAGS-1:0]     rank2_flags;
   logic [SSU_RANK_FLAGS-1:0]     rank3_flags;
   ssu_op_type                    next_op;
   logic [W-1:0]                  next_hold;
   logic                          next_complement_flag;
   logic                          next_recomplement;
   logic                          next_circular_mode;
   logic [SSU_RANK_FLAGS-1:0]     next_rank1_flags;
   logic [SSU_RANK_FLAGS-1:0]     next_rank2_flags;
   logic [SSU_RANK_FLAGS-1:0]     next_rank3_flags;
   logic [W-1:0]                  operand;
   logic [SSU_COUNT_WIDTH-1:0]    count;
   logic                          count_neg;
   logic                          over_63;
   logic                          rank_enable;

   // Decode, operand and count selection in the issue period.
   always_comb
   begin
      count_neg = count_reg[SSU_COUNT_SIGN_BIT];
      // Only three designator bits are looked at.
      if (!major_opcode[SSU_CLASS_BIT])
         next_op = SSU_OP_MASK;
      else
      begin
         unique case ({sub_opcode[SSU_SELECT_BIT], sub_opcode[SSU_DIR_BIT]})
            2'b00: next_op = SSU_OP_ROT_IMM;
            2'b01: next_op = SSU_OP_SHR_IMM;
            2'b10: next_op = SSU_OP_SHL_SRC;
            2'b11: next_op = SSU_OP_SHR_SRC;
         endcase
      end
      // Left rotations, including op 23 with a negative count.
      next_circular_mode = (next_op == SSU_OP_ROT_IMM)
         || (next_op == SSU_OP_SHL_SRC && !count_neg)
         || (next_op == SSU_OP_SHR_SRC && count_neg);
      // Operand from result_reg or source_reg by the select bit.
      operand = sub_opcode[SSU_SELECT_BIT] ? source_reg : result_reg;
      if (next_op == SSU_OP_MASK)
         next_hold = '0;
      else if (next_circular_mode)
         next_hold = {operand[W-1-SSU_PRE_ROTATE:0],
                      operand[W-1:W-SSU_PRE_ROTATE]};
      else
         next_hold = operand;
      next_recomplement = (next_op != SSU_OP_MASK)
         && !operand[SSU_WORD_SIGN_BIT];
      next_complement_flag = (next_op == SSU_OP_MASK)
         || operand[SSU_WORD_SIGN_BIT];
      // Count source, then inversion for 20 and 22 only.
      if (next_op == SSU_OP_SHL_SRC || next_op == SSU_OP_SHR_SRC)
         count = count_reg[SSU_COUNT_WIDTH-1:0];
      else
         count = count_field;
      if (next_op == SSU_OP_ROT_IMM || next_op == SSU_OP_SHL_SRC)
         count = ~count;
      // Register-count right shifts beyond 63 places.
      if (next_op == SSU_OP_SHL_SRC && count_neg)
         over_63 = ~&count_reg[SSU_COUNT_SIGN_BIT-1:SSU_COUNT_WIDTH];
      else if (next_op == SSU_OP_SHR_SRC && !count_neg)
         over_63 = |count_reg[SSU_COUNT_SIGN_BIT-1:SSU_COUNT_WIDTH];
      else
         over_63 = 1'b0;
      rank_enable      = !over_63;
      next_rank1_flags = flag_decode(count[1:0]);
      next_rank2_flags = flag_decode(count[3:2]);
      next_rank3_flags = rank_enable ? flag_decode(count[5:4])
                                     : '0;
   end

   // Issue-stage registers, loaded every period so a new issue may follow.
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         op              <= SSU_OP_ROT_IMM;
         hold            <= SSU_RESULT_RESET;
         complement_flag <= 1'b0;
         recomplement    <= 1'b0;
         circular_mode   <= 1'b0;
         rank1_flags     <= SSU_FLAGS_RESET;
         rank2_flags     <= SSU_FLAGS_RESET;
         rank3_flags     <= SSU_FLAGS_RESET;
      end
      else
      begin
         op              <= next_op;
         hold            <= next_hold;
         complement_flag <= next_complement_flag;
         recomplement    <= next_recomplement;
         circular_mode   <= next_circular_mode;
         rank1_flags     <= next_rank1_flags;
         rank2_flags     <= next_rank2_flags;
         rank3_flags     <= next_rank3_flags;
      end
   end

   // Execute-stage signals.
   logic [W-1:0] rank_in;
   logic [W-1:0] ranked;
   logic [W-1:0] rank_out;
   logic [W-1:0] next_result_data;
   logic         next_result_write;

   // Complement control, three ranks, output gate and sign control.
   always_comb
   begin
      // Mask: zeros complemented give all ones into rank one.
      rank_in = complement_flag ? ~hold : hold;
      ranked  = rank_shift(rank_in, rank1_flags, SSU_RANK1_STEP,
                           circular_mode);
      ranked  = rank_shift(ranked, rank2_flags, SSU_RANK2_STEP,
                           circular_mode);
      ranked  = rank_shift(ranked, rank3_flags, SSU_RANK3_STEP,
                           circular_mode);
      rank_out = output_valid_strobe ? ~ranked
                                     : {W{1'b1}};
      next_result_data  = result_data;
      next_result_write = output_valid_strobe;
      if (output_valid_strobe)
         next_result_data = recomplement ? ~rank_out
                                         : rank_out;
   end

   // Result register towards result_reg.
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         result_data  <= SSU_RESULT_RESET;
         result_write <= 1'b0;
      end
      else
      begin
         result_data  <= next_result_data;
         result_write <= next_result_write;
      end
   end

   // Checking aid: an independent reference for each presented operation.
   logic [W-1:0]                      chk_expect;
   logic                              chk_big;

   // Rotate left by n modulo the word.
   function automatic logic [W-1:0] chk_rotl(
      input logic [W-1:0] v, input logic [SSU_COUNT_WIDTH-1:0] n);
      logic [2*W-1:0]             d;
      logic [SSU_COUNT_WIDTH-1:0] m;
      m = (n >= 6'h3c) ? n - 6'h3c : n;
      d = {v, v} << m;
      return d[2*W-1:W];
   endfunction : chk_rotl

   // Arithmetic right shift.
   function automatic logic [W-1:0] chk_sra(
      input logic [W-1:0] v, input logic [SSU_COUNT_WIDTH-1:0] n);
      logic signed [W-1:0] s;
      s = v;
      s = s >>> n;
      return s;
   endfunction : chk_sra

   // Expected word for the operation presented in this period; the
   // assertions look at it again two edges later, when it is written.
   always_comb
   begin
      chk_big = count_reg[SSU_COUNT_SIGN_BIT]
         ? ~&count_reg[SSU_COUNT_SIGN_BIT-1:SSU_COUNT_WIDTH]
         : |count_reg[SSU_COUNT_SIGN_BIT-1:SSU_COUNT_WIDTH];
      unique case (next_op)
         SSU_OP_ROT_IMM: chk_expect = chk_rotl(result_reg, count_field);
         SSU_OP_SHR_IMM: chk_expect = chk_sra(result_reg, count_field);
         SSU_OP_SHL_SRC: chk_expect = count_reg[SSU_COUNT_SIGN_BIT]
            ? (chk_big ? {W{source_reg[W-1]}}
                       : chk_sra(source_reg, ~count_reg[5:0]))
            : chk_rotl(source_reg, count_reg[5:0]);
         SSU_OP_SHR_SRC: chk_expect = count_reg[SSU_COUNT_SIGN_BIT]
            ? chk_rotl(source_reg, ~count_reg[5:0])
            : (chk_big ? {W{source_reg[W-1]}}
                       : chk_sra(source_reg, count_reg[5:0]));
         SSU_OP_MASK:    chk_expect = ~({W{1'b1}} >> count_field);
         default:        chk_expect = '0;
      endcase
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   AST_ROT_IMM: assert property (
      output_valid_strobe && op == SSU_OP_ROT_IMM
      |=> result_data == $past(chk_expect, 2))
      else $error("Immediate left rotation result is wrong.");
   AST_SHR_IMM: assert property (
      output_valid_strobe && op == SSU_OP_SHR_IMM
      |=> result_data == $past(chk_expect, 2))
      else $error("Immediate right shift result is wrong.");
   AST_SHL_SRC: assert property (
      output_valid_strobe && op == SSU_OP_SHL_SRC
      |=> result_data == $past(chk_expect, 2))
      else $error("Register-count left shift result is wrong.");
   AST_SHR_SRC: assert property (
      output_valid_strobe && op == SSU_OP_SHR_SRC
      |=> result_data == $past(chk_expect, 2))
      else $error("Register-count right shift result is wrong.");
   AST_MASK: assert property (
      output_valid_strobe && op == SSU_OP_MASK
      |=> result_data == $past(chk_expect, 2))
      else $error("Mask result is wrong.");
   AST_HOLD_IDLE: assert property (
      !output_valid_strobe |=> !result_write && $stable(result_data))
      else $error("Result changed without the strobe.");
   AST_WRITE_TIMING: assert property (
      output_valid_strobe |=> result_write)
      else $error("Result write did not follow the strobe.");
   AST_FLAGS_ONEHOT: assert property (
      $onehot(rank1_flags) && $onehot(rank2_flags)
      && $onehot0(rank3_flags))
      else $error("Rank flags are not one-hot.");
   AST_OVER_63: assert property (
      over_63 ##1 output_valid_strobe |-> rank3_flags == '0
      ##1 result_write && result_data == {W{$past(source_reg[W-1], 2)}})
      else $error("Large right shift did not deliver pure sign fill.");
   AST_CIRCULAR: assert property (
      major_opcode[SSU_CLASS_BIT] && sub_opcode[1:0] == 2'b00
      |=> circular_mode && !complement_flag == recomplement)
      else $error("Left rotation did not enter circular mode.");
   AST_MASK_FILL: assert property (
      !major_opcode[SSU_CLASS_BIT] |=> hold == '0 && complement_flag
      && !circular_mode)
      else $error("Mask did not load zeros with complement.");

   COV_ROT_IMM: cover property (
      output_valid_strobe && op == SSU_OP_ROT_IMM);
   COV_NEG_LEFT: cover property (
      output_valid_strobe && op == SSU_OP_SHR_SRC && circular_mode);
   COV_BIG_RIGHT: cover property (over_63 ##1 output_valid_strobe);
   COV_BACK_TO_BACK: cover property (
      output_valid_strobe [*3]);

endmodule : ssu_shift_unit

// ===== ssu_issue_model.sv
// Issue logic model that raises the go strobe after each issue unless drop_strobe withholds it.
`timescale 1ns/100ps

module ssu_issue_model
(
   // Clock and reset.
   input  wire logic clock,
   input  wire logic rst,
   // Issue request from the bench and a command to withhold the strobe.
   input  wire logic issue,
   input  wire logic drop_strobe,
   // Go strobe towards the shift unit.
   output logic      output_valid_strobe
);

   // The strobe follows each issue by one period unless it is withheld.
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         output_valid_strobe <= 1'b0;
      else
         output_valid_strobe <= issue & ~drop_strobe;
   end

endmodule : ssu_issue_model

// ===== testbench.sv
// Self-checking bench for the sixty-bit shift unit.
`timescale 1ns/100ps

`define CHECK(got, exp) \
   begin \
      cmp_count++; \
      if ((got) !== (exp)) \
      begin \
         errors++; \
         $display("unexpected at %0t: got %h expected %h", \
                  $time, got, exp); \
      end \
   end

module testbench;
   import ssu_pkg::*;

   localparam int SW = SSU_WORD_WIDTH;

   logic          clock = 1'b0;
   logic          rst = 1'b1;
   logic [2:0]    major_opcode = '0;
   logic [2:0]    sub_opcode = '0;
   logic [5:0]    count_field = '0;
   logic [SW-1:0] result_reg = '0;
   logic [SW-1:0] source_reg = '0;
   logic [17:0]   count_reg = '0;
   logic          issue = 1'b0;
   logic          drop_strobe = 1'b0;
   logic          output_valid_strobe;
   logic [SW-1:0] result_data;
   logic          result_write;
   logic [SW-1:0] exp_q[$];
   logic [SW-1:0] last_exp = '0;
   int            errors = 0;
   int            cmp_count = 0;
   int            seed = 32'h171e807c;
   int            cnts[12] = '{0, 1, 2, 3, 4, 12, 16, 48, 59, 60, 61, 63};
   logic [17:0]   big[4] = '{18'h00040, 18'h0ffc0, 18'h3ffbf, 18'h2003f};

   // Clock of 100 MHz.
   always #5 clock = ~clock;

   ssu_issue_model ssu_issue_model_i
   (
      .clock               (clock),
      .rst                 (rst),
      .issue               (issue),
      .drop_strobe         (drop_strobe),
      .output_valid_strobe (output_valid_strobe)
   );

   ssu_shift_unit ssu_shift_unit_i
   (
      .clock               (clock),
      .rst                 (rst),
      .major_opcode        (major_opcode),
      .sub_opcode          (sub_opcode),
      .count_field         (count_field),
      .result_reg          (result_reg),
      .source_reg          (source_reg),
      .count_reg           (count_reg),
      .output_valid_strobe (output_valid_strobe),
      .result_data         (result_data),
      .result_write        (result_write)
   );

   // Left rotation; counts of 60 and more wrap around the word.
   function automatic logic [SW-1:0] rotl(input logic [SW-1:0] v,
                                          input int n);
      int k;
      k = n % SW;
      return (v << k) | (v >> (SW - k));
   endfunction : rotl

   // Arithmetic right shift; long counts leave only sign bits.
   function automatic logic [SW-1:0] sra(input logic [SW-1:0] v,
                                         input int n);
      logic signed [SW-1:0] s;
      s = v;
      return s >>> ((n > SW - 1) ? SW - 1 : n);
   endfunction : sra

   // Behavioural result of one operation, index 0..3 for 20..23, 4 mask.
   function automatic logic [SW-1:0] ref_result(input int op,
      input logic [5:0] cf, input logic [SW-1:0] xi,
      input logic [SW-1:0] xk, input logic [17:0] cr);
      case (op)
         0: return rotl(xi, cf);
         1: return sra(xi, cf);
         2: return cr[17] ? sra(xk, 17'h1ffff ^ cr[16:0]) : rotl(xk, cr[5:0]);
         3: return cr[17] ? rotl(xk, 6'h3f ^ cr[5:0]) : sra(xk, cr[16:0]);
         default: return ~({SW{1'b1}} >> cf);
      endcase
   endfunction : ref_result

   // Presents one issue for one period; major bits 0,2 and sub bit 2 are random.
   task automatic issue_op(input int op, input logic [5:0] cf,
                           input logic [17:0] cr, input bit neg,
                           input bit go);
      logic [63:0] a;
      logic [63:0] b;
      a = {$random(seed), $random(seed)};
      b = {$random(seed), $random(seed)};
      a[SW-1] = neg;
      b[SW-1] = neg;
      major_opcode = {a[63], (op != 4), a[62]};
      sub_opcode = {a[61], (op == 4) ? 2'h3 : 2'(op)};
      count_field = cf;
      result_reg = a[SW-1:0];
      source_reg = b[SW-1:0];
      count_reg = cr;
      issue = 1'b1;
      drop_strobe = !go;
      if (go)
         exp_q.push_back(ref_result(op, cf, a[SW-1:0], b[SW-1:0], cr));
      @(posedge clock);
      #1;
   endtask : issue_op

   // Leaves the unit without issues for a number of periods.
   task automatic idle(input int n);
      issue = 1'b0;
      drop_strobe = 1'b0;
      repeat (n) @(posedge clock);
      #1;
   endtask : idle

   // Prints the counts and the verdict, then ends the run.
   task automatic print_verdict();
      `CHECK(exp_q.size(), 0)
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : print_verdict

   // Compares every write with the queue and checks that data holds.
   always @(negedge clock)
   begin
      if (rst)
      begin
         last_exp = '0;
         `CHECK({result_write, result_data}, 61'h0)
      end
      else if (result_write === 1'b1)
      begin
         `CHECK(exp_q.size() > 0, 1'b1)
         if (exp_q.size() > 0)
            last_exp = exp_q.pop_front();
         `CHECK(result_data, last_exp)
      end
      else
         `CHECK(result_data, last_exp)
   end

   // Cuts a hang short well beyond the expected run length.
   initial
   begin
      #100000;
      errors++;
      print_verdict();
   end

   // Main sequence: counts table per operation, then random traffic.
   initial
   begin
      repeat (20) @(posedge clock);
      #1;
      rst = 1'b0;
      foreach (cnts[i])
         for (int s = 0; s < 2; s++)
         begin
            issue_op(0, cnts[i], '0, s, 1);
            issue_op(1, cnts[i], '0, s, 1);
            issue_op(4, cnts[i], '0, s, 1);
         end
      idle(3);
      $display("test immediate counts done");
      foreach (cnts[i])
         for (int s = 0; s < 2; s++)
         begin
            issue_op(2, cnts[i], 18'(cnts[i]), s, 1);
            issue_op(2, 0, ~18'(cnts[i]), s, 1);
            issue_op(3, cnts[i], 18'(cnts[i]), s, 1);
            issue_op(3, 0, ~18'(cnts[i]), s, 1);
         end
      foreach (big[i])
         for (int s = 0; s < 2; s++)
         begin
            issue_op(2, 0, big[i], s, 1);
            issue_op(3, 0, big[i], s, 1);
         end
      idle(3);
      $display("test register counts done");
      issue_op(0, 6'h05, '0, 0, 0);
      issue_op(4, 6'h3f, '0, 1, 0);
      idle(4);
      $display("test withheld strobe done");
      for (int i = 0; i < 300; i++)
         issue_op(($random(seed) & 32'h7fffffff) % 5, 6'($random(seed)),
                  18'($random(seed)), $random(seed),
                  ($random(seed) & 7) != 0);
      idle(3);
      $display("test random traffic done");
      rst = 1'b1;
      idle(3);
      rst = 1'b0;
      issue_op(0, 6'h01, '0, 1, 1);
      issue_op(3, 0, 18'h00001, 1, 1);
      idle(4);
      $display("test reset in mid run done");
      print_verdict();
   end

endmodule : testbench
